//--- pkg/charge_ctl_pkg.sv
// Summary of operation
// - sleep after host line low over ten seconds while sense below threshold.
// - asleep, every count and timebase stops until woken.
// - host line rising wakes the block; idle timer starts from zero, self-discharge timebase resumes.
// - activity output driven low when sense exceeds threshold in normal state.
// - activity output released whenever sense is below threshold, any state.
// - compare magnitude of sense plus internal offset against threshold.
// - integrate sense; battery side above pack side is charge, else discharge.
// - self-discharge rate doubles per ten degrees above 25 degrees Celsius.
// - block stores measured offset itself at assembly; host may read it.
// - host line is open drain, only pulled low, never driven high.
// - 128 bytes of retained memory, top 13 reserved for status.
// - threshold is 3.84 mV over field value 1..7; zero is invalid.
// - mode and threshold config resets to 0eh, lowest threshold.
package charge_ctl_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int SLEEP_TIME_S = 10;
   localparam longint SLEEP_CYCLES_L = longint'(SLEEP_TIME_S) * CLK_HZ;
   localparam int SENSE_W = 16; // signed sense sample, 1 lsb = 1 uV
   localparam int OFS_W = 8;
   localparam int CNT_W = 16;
   localparam int ACC_W = 32;
   localparam int MEM_DEPTH = 128;
   localparam int MEM_AW = 7;
   localparam int MEM_RSVD = 13;
   localparam logic [MEM_AW-1:0] MEM_RSVD_BASE = 7'h73;
   localparam logic [7:0] MODE_CFG_RESET = 8'h0E;
   localparam int THR_LSB = 1;
   localparam int THR_MSB = 3;
   localparam logic [SENSE_W-1:0] THR_FULL_UV = 16'h0F00; // 3840 uV
   // integration quantum per count, in uV-samples (arbitrary scaling)
   localparam logic [ACC_W-1:0] COUNT_QUANTUM = 32'h0001_0000;
   localparam int TEMP_W = 3;
   localparam logic [TEMP_W-1:0] TEMP_NOMINAL = 3'h3; // 20..30 C band
   localparam int SELF_BASE_W = 24;
   localparam logic [SELF_BASE_W-1:0] SELF_BASE_PERIOD = 24'hFF_FFFF;
   typedef enum logic [1:0] {ST_NORMAL = 2'b00, ST_SLEEP = 2'b01} op_state_e;
endpackage

//--- rtl/sync3.sv
`timescale 1ns/100ps
// three-stage input synchroniser; change accepted when stages 2 and 3 agree
module sync3 (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic d_in,
   output logic q_out
);
   logic s1, s2, s3;
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         q_out <= 1'b0;
      end else begin
         s1 <= d_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) q_out <= s3;
      end
   end
endmodule

//--- rtl/charge_counter_state_control.sv
`timescale 1ns/100ps
module charge_counter_state_control
   import charge_ctl_pkg::*;
#(
   parameter longint SLEEP_CYCLES = SLEEP_CYCLES_L
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic host_serial_line_in,
   input wire logic host_line_pull_low_req_in,
   input wire logic sense_valid_in,
   input wire logic signed [SENSE_W-1:0] sense_battery_side_in,
   input wire logic signed [SENSE_W-1:0] sense_pack_side_in,
   input wire logic [TEMP_W-1:0] temp_step_in,
   input wire logic offset_store_in,
   input wire logic signed [OFS_W-1:0] offset_measured_in,
   input wire logic cfg_write_in,
   input wire logic [7:0] cfg_data_in,
   input wire logic clear_charge_in,
   input wire logic clear_discharge_in,
   input wire logic clear_self_in,
   input wire logic mem_write_in,
   input wire logic [MEM_AW-1:0] mem_addr_in,
   input wire logic [7:0] mem_wdata_in,
   output logic host_serial_line_out,
   output logic host_serial_line_oe_n_out,
   output logic activity_out,
   output logic activity_oe_n_out,
   output logic asleep_out,
   output logic [CNT_W-1:0] charge_count_out,
   output logic [CNT_W-1:0] discharge_count_out,
   output logic [CNT_W-1:0] self_discharge_count_out,
   output logic [OFS_W-1:0] offset_cancel_reg_out,
   output logic [7:0] mode_threshold_config_out,
   output logic [7:0] mem_rdata_out
);
   localparam int TW = $clog2(SLEEP_CYCLES + 1);

   op_state_e state;
   logic line_s, line_d;
   logic [TW-1:0] idle_cnt;
   logic [7:0] mode_threshold_config;
   logic [OFS_W-1:0] offset_cancel_reg;
   logic active;
   logic signed [SENSE_W:0] eff_sense;
   logic [SENSE_W:0] eff_mag;
   logic [SENSE_W-1:0] thr;
   logic [2:0] thr_field;
   logic [ACC_W-1:0] chg_acc, dis_acc;
   logic [SELF_BASE_W+4:0] self_acc;
   logic [7:0] self_inc;
   logic [CNT_W-1:0] charge_count, discharge_count, self_discharge_count;
   logic [7:0] mem [MEM_DEPTH];
   logic running;
   logic line_rise;
   logic line_low_s;

   // host line crosses into this clock domain; the inverted level is
   // synchronised so reset leaves the copy at the line's idle-high state
   sync3 u_line_sync (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .d_in(~host_serial_line_in),
      .q_out(line_low_s)
   );

   assign line_s = ~line_low_s;
   assign running = (state == ST_NORMAL);
   assign line_rise = line_s & ~line_d;
   assign thr_field = mode_threshold_config[THR_MSB:THR_LSB];

   // effective sense = difference plus stored offset, magnitude compared
   always_comb begin
      eff_sense = (SENSE_W+1)'(sense_battery_side_in)
                - (SENSE_W+1)'(sense_pack_side_in)
                + (SENSE_W+1)'(signed'(offset_cancel_reg));
      eff_mag = eff_sense[SENSE_W] ? (SENSE_W+1)'(-eff_sense)
                                   : eff_sense;
      // field zero yields no threshold: activity never flagged
      thr = (thr_field == 3'h0) ? '0
          : SENSE_W'(THR_FULL_UV / thr_field);
      active = (thr_field != 3'h0) && (eff_mag > (SENSE_W+1)'(thr));
   end

   // self-discharge increment per cycle: doubles per temperature step
   always_comb begin
      // eight bits so the hottest band, x16, does not wrap to zero
      self_inc = 8'h01 << temp_step_in; // step 3 gives 8, nominal
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) line_d <= 1'b1; // idle high: no false rise after reset
      else line_d <= line_s;
   end

   // sleep timeout restarts on line high or activity
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         idle_cnt <= '0;
      end else if (line_s || active || !running) begin
         idle_cnt <= '0;
      end else if (idle_cnt <= TW'(SLEEP_CYCLES)) begin
         idle_cnt <= idle_cnt + TW'(1);
      end
   end

   // operating state: sleep on long idle, wake on line rising
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= ST_NORMAL;
      end else begin
         unique case (state)
            ST_NORMAL: begin
               if (idle_cnt > TW'(SLEEP_CYCLES) && !active && !line_s)
                  state <= ST_SLEEP;
            end
            ST_SLEEP: begin
               if (line_rise) state <= ST_NORMAL;
            end
            default: state <= ST_NORMAL;
         endcase
      end
   end

   // configuration register, host writes it via the protocol engine
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) mode_threshold_config <= MODE_CFG_RESET;
      else if (cfg_write_in && running) mode_threshold_config <= cfg_data_in;
   end

   // offset stored by the block itself during assembly calibration
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) offset_cancel_reg <= '0;
      else if (offset_store_in && running)
         offset_cancel_reg <= offset_measured_in;
   end

   // charge/discharge integration; counters only cleared by host request
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         chg_acc <= '0;
         dis_acc <= '0;
         charge_count <= '0;
         discharge_count <= '0;
      end else if (running) begin
         if (clear_charge_in) begin
            chg_acc <= '0;
            charge_count <= '0;
         end else if (sense_valid_in && !eff_sense[SENSE_W]) begin
            if (chg_acc + ACC_W'(eff_mag) >= COUNT_QUANTUM) begin
               chg_acc <= chg_acc + ACC_W'(eff_mag) - COUNT_QUANTUM;
               charge_count <= charge_count + CNT_W'(1);
            end else begin
               chg_acc <= chg_acc + ACC_W'(eff_mag);
            end
         end
         if (clear_discharge_in) begin
            dis_acc <= '0;
            discharge_count <= '0;
         end else if (sense_valid_in && eff_sense[SENSE_W]) begin
            if (dis_acc + ACC_W'(eff_mag) >= COUNT_QUANTUM) begin
               dis_acc <= dis_acc + ACC_W'(eff_mag) - COUNT_QUANTUM;
               discharge_count <= discharge_count + CNT_W'(1);
            end else begin
               dis_acc <= dis_acc + ACC_W'(eff_mag);
            end
         end
      end
   end

   // self-discharge timebase, scaled by temperature
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         self_acc <= '0;
         self_discharge_count <= '0;
      end else if (running) begin
         if (clear_self_in) begin
            self_acc <= '0;
            self_discharge_count <= '0;
         end else if (self_acc + (SELF_BASE_W+5)'(self_inc)
                      >= (SELF_BASE_W+5)'({SELF_BASE_PERIOD, 3'h0})) begin
            self_acc <= self_acc + (SELF_BASE_W+5)'(self_inc)
                      - (SELF_BASE_W+5)'({SELF_BASE_PERIOD, 3'h0});
            self_discharge_count <= self_discharge_count + CNT_W'(1);
         end else begin
            self_acc <= self_acc + (SELF_BASE_W+5)'(self_inc);
         end
      end
   end

   // retained byte memory; top locations shadow status
   always_ff @(posedge ref_clk_in) begin
      if (mem_write_in && running && mem_addr_in < MEM_RSVD_BASE)
         mem[mem_addr_in] <= mem_wdata_in;
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mem_rdata_out <= '0;
      end else if (mem_addr_in >= MEM_RSVD_BASE) begin
         unique case (mem_addr_in - MEM_RSVD_BASE)
            7'h0: mem_rdata_out <= charge_count[7:0];
            7'h1: mem_rdata_out <= charge_count[15:8];
            7'h2: mem_rdata_out <= discharge_count[7:0];
            7'h3: mem_rdata_out <= discharge_count[15:8];
            7'h4: mem_rdata_out <= self_discharge_count[7:0];
            7'h5: mem_rdata_out <= self_discharge_count[15:8];
            7'h6: mem_rdata_out <= offset_cancel_reg;
            7'h7: mem_rdata_out <= mode_threshold_config;
            7'h8: mem_rdata_out <= {5'h00, temp_step_in};
            default: mem_rdata_out <= '0;
         endcase
      end else begin
         mem_rdata_out <= mem[mem_addr_in];
      end
   end

   // registered outputs; open-drain pins only ever drive low
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         host_serial_line_out <= 1'b0;
         host_serial_line_oe_n_out <= 1'b1;
         activity_out <= 1'b0;
         activity_oe_n_out <= 1'b1;
         asleep_out <= 1'b0;
      end else begin
         host_serial_line_out <= 1'b0;
         host_serial_line_oe_n_out <= ~(host_line_pull_low_req_in
                                        && running);
         activity_out <= 1'b0;
         // drive low only when active and normal; else high impedance
         activity_oe_n_out <= ~(active && running);
         asleep_out <= ~running;
      end
   end

   assign charge_count_out = charge_count;
   assign discharge_count_out = discharge_count;
   assign self_discharge_count_out = self_discharge_count;
   assign offset_cancel_reg_out = offset_cancel_reg;
   assign mode_threshold_config_out = mode_threshold_config;
endmodule

//--- tb/charge_ctl_assertions.sv
`timescale 1ns/100ps
module charge_ctl_assertions
   import charge_ctl_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic host_serial_line_in,
   input wire logic offset_store_in,
   input wire logic signed [OFS_W-1:0] offset_measured_in,
   input wire logic clear_charge_in,
   input wire logic host_serial_line_out,
   input wire logic activity_out,
   input wire logic activity_oe_n_out,
   input wire logic asleep_out,
   input wire logic [CNT_W-1:0] charge_count_out,
   input wire logic [OFS_W-1:0] offset_cancel_reg_out,
   input wire logic [7:0] mode_threshold_config_out
);
   // one domain, so clock and reset are given once
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // open-drain pins: data stays low, only the enable may move
   a_line_only_low: assert property (host_serial_line_out == 1'b0)
      else $error("host line data not low");
   a_activity_low: assert property (activity_out == 1'b0)
      else $error("activity data not low");
   // sleep needs a long low line and a released activity pin
   a_sleep_entry: assert property (
      $rose(asleep_out) |-> !$past(host_serial_line_in, 8) && activity_oe_n_out)
      else $error("sleep entered too early");
   a_sleep_frozen: assert property (
      asleep_out && $past(asleep_out) |-> $stable(charge_count_out))
      else $error("count moved in sleep");
   // sync lag plus two edges must fit in ten cycles
   a_wake_on_high: assert property (
      $rose(host_serial_line_in) && asleep_out |-> ##[1:10] !asleep_out)
      else $error("no wake after line high");
   a_cfg_reset: assert property (
      $rose(rstn_in) |-> mode_threshold_config_out == MODE_CFG_RESET)
      else $error("config reset value wrong");
   // asleep_out lags the state a cycle; a request refused on sleep entry
   // shows up as asleep_out high in the following cycle
   a_clear_count: assert property (
      clear_charge_in && !asleep_out |=>
      asleep_out || charge_count_out == 16'h0000)
      else $error("count not cleared");
   a_offset_store: assert property (
      offset_store_in && !asleep_out |=>
      asleep_out || offset_cancel_reg_out == $past(offset_measured_in))
      else $error("offset not stored");
   a_sleep_released: assert property (
      asleep_out |-> activity_oe_n_out)
      else $error("activity driven in sleep");
endmodule

//--- tb/host_line_model.sv
`timescale 1ns/100ps
// host end of the single-wire line: pull-up plus host pull-down
module host_line_model (
   input wire logic hold_low_in,
   input wire logic dev_oe_n_in,
   output logic line_out
);
   // wired-and; a released line reads the pull-up, not a stale value
   assign line_out = !(hold_low_in || !dev_oe_n_in);
endmodule

//--- tb/charge_counter_state_control_bench.sv
`timescale 1ns/100ps
module charge_counter_state_control_bench;
   import charge_ctl_pkg::*;
   logic ref_clk_in = 1'b0, rstn_in = 1'b0, host_hold = 1'b0;
   logic host_line_pull_low_req_in = 1'b0, sense_valid_in = 1'b1;
   logic offset_store_in = 1'b0, cfg_write_in = 1'b0, mem_write_in = 1'b0;
   logic clear_charge_in = 1'b0, clear_discharge_in = 1'b0;
   logic clear_self_in = 1'b0, host_serial_line_in;
   logic signed [SENSE_W-1:0] sense_battery_side_in, sense_pack_side_in;
   logic [TEMP_W-1:0] temp_step_in = TEMP_NOMINAL;
   logic signed [OFS_W-1:0] offset_measured_in = 8'h00;
   logic [7:0] cfg_data_in = 8'h00, mem_wdata_in = 8'h00;
   logic [MEM_AW-1:0] mem_addr_in = 7'h00;
   logic host_serial_line_out, host_serial_line_oe_n_out, activity_out;
   logic activity_oe_n_out, asleep_out;
   logic [CNT_W-1:0] charge_count_out, discharge_count_out;
   logic [CNT_W-1:0] self_discharge_count_out;
   logic [OFS_W-1:0] offset_cancel_reg_out;
   logic [7:0] mode_threshold_config_out, mem_rdata_out;
   int n_errors = 0, checks_done = 0, cycles = 0;
   // short idle timeout keeps the run brief
   charge_counter_state_control #(.SLEEP_CYCLES(50)) dut_u (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .host_serial_line_in(host_serial_line_in),
      .host_line_pull_low_req_in(host_line_pull_low_req_in),
      .sense_valid_in(sense_valid_in),
      .sense_battery_side_in(sense_battery_side_in),
      .sense_pack_side_in(sense_pack_side_in),
      .temp_step_in(temp_step_in),
      .offset_store_in(offset_store_in),
      .offset_measured_in(offset_measured_in),
      .cfg_write_in(cfg_write_in),
      .cfg_data_in(cfg_data_in),
      .clear_charge_in(clear_charge_in),
      .clear_discharge_in(clear_discharge_in),
      .clear_self_in(clear_self_in),
      .mem_write_in(mem_write_in),
      .mem_addr_in(mem_addr_in),
      .mem_wdata_in(mem_wdata_in),
      .host_serial_line_out(host_serial_line_out),
      .host_serial_line_oe_n_out(host_serial_line_oe_n_out),
      .activity_out(activity_out),
      .activity_oe_n_out(activity_oe_n_out),
      .asleep_out(asleep_out),
      .charge_count_out(charge_count_out),
      .discharge_count_out(discharge_count_out),
      .self_discharge_count_out(self_discharge_count_out),
      .offset_cancel_reg_out(offset_cancel_reg_out),
      .mode_threshold_config_out(mode_threshold_config_out),
      .mem_rdata_out(mem_rdata_out)
   );
   host_line_model host_u (.hold_low_in(host_hold),
      .dev_oe_n_in(host_serial_line_oe_n_out),
      .line_out(host_serial_line_in));
   initial forever #20 ref_clk_in = ~ref_clk_in;
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         $display("unexpected t=%0t timeout", $time);
         summarize();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic sns(input logic [15:0] b, input logic [15:0] p);
      sense_battery_side_in = b;
      sense_pack_side_in = p;
   endtask
   task automatic do_reset();
      sns(16'h0000, 16'h0000);
      rstn_in = 1'b0;
      cyc(4);
      rstn_in = 1'b1;
      cyc(1);
   endtask
   // threshold 548 uV after reset; offset 100 turns -600 into -500
   task automatic t_thresh();
      do_reset();
      chk(mode_threshold_config_out, 16'h000E);
      sns(16'h0258, 16'h0000);
      cyc(3);
      chk(activity_oe_n_out, 16'h0000);
      sns(16'h0000, 16'h0258);
      offset_measured_in = 8'h64;
      offset_store_in = 1'b1;
      cyc(1);
      offset_store_in = 1'b0;
      cyc(3);
      chk(offset_cancel_reg_out, 16'h0064);
      chk(activity_oe_n_out, 16'h0001);
      // host reads the stored offset back from status to correct counts
      mem_addr_in = 7'h79;
      cyc(2);
      chk(mem_rdata_out, 16'h0064);
      cfg_data_in = 8'h02;
      cfg_write_in = 1'b1;
      cyc(1);
      cfg_write_in = 1'b0;
      sns(16'h0E10, 16'h0000);
      cyc(3);
      chk(activity_oe_n_out, 16'h0001);
      sns(16'h0F00, 16'h0000);
      cyc(3);
      chk(activity_oe_n_out, 16'h0000);
   endtask
   // 40 samples of 3840 uV give two quanta each way
   task automatic t_count();
      do_reset();
      sns(16'h0000, 16'hF100);
      cyc(40);
      sns(16'h0000, 16'h0F00);
      cyc(40);
      sns(16'h0000, 16'h0000);
      cyc(3);
      chk(charge_count_out, 16'h0002);
      chk(discharge_count_out, 16'h0002);
      // one self count takes far longer than this run at nominal temperature
      chk(self_discharge_count_out, 16'h0000);
      clear_charge_in = 1'b1;
      cyc(1);
      clear_charge_in = 1'b0;
      cyc(2);
      chk(charge_count_out, 16'h0000);
      chk(discharge_count_out, 16'h0002);
      clear_discharge_in = 1'b1;
      cyc(1);
      clear_discharge_in = 1'b0;
      cyc(2);
      chk(discharge_count_out, 16'h0000);
   endtask
   task automatic t_sleep();
      do_reset();
      sns(16'h0258, 16'h0000);
      host_hold = 1'b1;
      cyc(80);
      chk(asleep_out, 16'h0000);
      sns(16'h0000, 16'h0000);
      cyc(70);
      chk(asleep_out, 16'h0001);
      sns(16'h0F00, 16'h0000);
      cyc(40);
      chk(charge_count_out, 16'h0000);
      host_hold = 1'b0;
      cyc(10);
      chk(asleep_out, 16'h0000);
      host_line_pull_low_req_in = 1'b1;
      cyc(3);
      chk(host_serial_line_in, 16'h0000);
      host_line_pull_low_req_in = 1'b0;
   endtask
   // status area is read-only: config shows through at 7A
   task automatic t_mem();
      mem_addr_in = 7'h10;
      mem_wdata_in = 8'hA5;
      mem_write_in = 1'b1;
      cyc(1);
      mem_write_in = 1'b0;
      cyc(1);
      chk(mem_rdata_out, 16'h00A5);
      mem_addr_in = 7'h7A;
      mem_write_in = 1'b1;
      cyc(1);
      mem_write_in = 1'b0;
      cyc(1);
      chk(mem_rdata_out, 16'h000E);
      mem_addr_in = 7'h7B;
      cyc(2);
      chk(mem_rdata_out, 16'h0003);
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      t_thresh();
      t_count();
      t_sleep();
      t_mem();
      summarize();
   end
endmodule
bind charge_counter_state_control charge_ctl_assertions chk_u (
   .ref_clk_in(ref_clk_in),
   .rstn_in(rstn_in),
   .host_serial_line_in(host_serial_line_in),
   .offset_store_in(offset_store_in),
   .offset_measured_in(offset_measured_in),
   .clear_charge_in(clear_charge_in),
   .host_serial_line_out(host_serial_line_out),
   .activity_out(activity_out),
   .activity_oe_n_out(activity_oe_n_out),
   .asleep_out(asleep_out),
   .charge_count_out(charge_count_out),
   .offset_cancel_reg_out(offset_cancel_reg_out),
   .mode_threshold_config_out(mode_threshold_config_out)
);
